// file: design/ogac_pkg.sv
// Shared constants and state types of the overcurrent gate and alert block.
package ogac_pkg;
	// =====================================================
	// Bus addressing
	// =====================================================
	// Own fixed 7-bit slave address.
	localparam logic [6:0] OWN_ADDR = 7'h47;
	// Alert response address.
	localparam logic [6:0] ARA_ADDR = 7'h0C;
	// Byte returned on the alert response address.
	localparam logic [7:0] ARA_REPLY = 8'h8F;
	// Byte returned for reads of the own address (bus left released).
	localparam logic [7:0] IDLE_BYTE = 8'hFF;
	// Bits in one byte.
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// =====================================================
	// Timing
	// =====================================================
	// Logic clock rate in hertz.
	localparam longint unsigned CLK_HZ = 64'd50000000;
	// Reset timeout after the release threshold, in milliseconds.
	localparam longint unsigned POR_TIME_MS = 64'd25;
	// Reset timeout in logic clock cycles.
	localparam longint unsigned POR_CYCLES = POR_TIME_MS * CLK_HZ / 64'd1000;
	// Width of the reset timeout counter.
	localparam int POR_CNT_W = 24;

	// =====================================================
	// State types
	// =====================================================
	// Power-on reset sequencer states.
	typedef enum logic [2:0] {
		RS_HOLD = 3'h1,
		RS_WAIT = 3'h2,
		RS_RUN = 3'h4
	} ogac_rst_e;

	// Bus slave states.
	typedef enum logic [6:0] {
		SS_IDLE = 7'h01,
		SS_ADDR = 7'h02,
		SS_ACKA = 7'h04,
		SS_RX = 7'h08,
		SS_ACKRX = 7'h10,
		SS_TX = 7'h20,
		SS_ACKTX = 7'h40
	} ogac_slv_e;
endpackage

// file: design/ogac_smbus_slave.sv
// Slave-only two-wire bus front end running on the link clock.
`timescale 1ns/100ps
module ogac_smbus_slave (
	input wire logic linkClk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic alertPending,
	output logic sdaOe,
	output logic araToggle
);
	// =====================================================
	// Pin sampling
	// =====================================================
	// Synchronised bus lines and the alert level from the logic clock.
	logic [2:0] syncQ;
	// Previous synchronised bus line values for edge detection.
	logic prevScl;
	logic prevSda;
	logic sclS;
	logic sdaS;
	logic pendS;

	ogac_sync #(.WIDTH(3)) uSync (
		.clk(linkClk),
		.rst_b(rst_b),
		.d({alertPending, sdaIn, sclIn}),
		.q(syncQ)
	);

	assign sclS = syncQ[0];
	assign sdaS = syncQ[1];
	assign pendS = syncQ[2];

	// Edges and bus conditions derived from the second stage only.
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	assign sclRise = sclS & ~prevScl;
	assign sclFall = prevScl & ~sclS;
	assign startCond = sclS & prevScl & prevSda & ~sdaS;
	assign stopCond = sclS & prevScl & ~prevSda & sdaS;

	// Keep the previous line values.
	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			prevScl <= 1'b1;
			prevSda <= 1'b1;
		end else begin
			prevScl <= sclS;
			prevSda <= sdaS;
		end
	end

	// =====================================================
	// Transfer state machine
	// =====================================================
	ogac_pkg::ogac_slv_e state;
	// Received or outgoing byte.
	logic [7:0] shiftReg;
	// Bits handled in the current byte.
	logic [3:0] bitCnt;
	// The transfer is a read.
	logic isRead;
	// The transfer addresses the alert response address.
	logic isAra;

	// Address match: own address either way, or the alert address as a read while pending.
	function automatic logic addrMatch(input logic [7:0] a, input logic pend);
		addrMatch = (a[7:1] == ogac_pkg::OWN_ADDR) ||
			((a[7:1] == ogac_pkg::ARA_ADDR) && a[0] && pend);
	endfunction

	// The slave only ever answers: it drives data or an acknowledge after the
	// host has addressed it and never creates a start itself.
	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ogac_pkg::SS_IDLE;
			shiftReg <= 8'h00;
			bitCnt <= 4'h0;
			isRead <= 1'b0;
			isAra <= 1'b0;
			sdaOe <= 1'b0;
			araToggle <= 1'b0;
		end else if (startCond) begin
			// A start, repeated or not, always restarts address capture.
			state <= ogac_pkg::SS_ADDR;
			bitCnt <= 4'h0;
			sdaOe <= 1'b0;
		end else if (stopCond) begin
			state <= ogac_pkg::SS_IDLE;
			sdaOe <= 1'b0;
		end else begin
			case (state)
				ogac_pkg::SS_ADDR, ogac_pkg::SS_RX: begin
					if (sclRise && bitCnt < ogac_pkg::BYTE_BITS) begin
						shiftReg <= {shiftReg[6:0], sdaS};
						bitCnt <= bitCnt + 4'h1;
					end else if (sclFall && bitCnt == ogac_pkg::BYTE_BITS) begin
						if (state == ogac_pkg::SS_RX) begin
							// Data to the own address is acknowledged and dropped.
							state <= ogac_pkg::SS_ACKRX;
							sdaOe <= 1'b1;
						end else if (addrMatch(shiftReg, pendS)) begin
							state <= ogac_pkg::SS_ACKA;
							isRead <= shiftReg[0];
							isAra <= (shiftReg[7:1] == ogac_pkg::ARA_ADDR);
							sdaOe <= 1'b1;
						end else begin
							// Another slave is addressed: stay off the bus.
							state <= ogac_pkg::SS_IDLE;
						end
					end
				end
				ogac_pkg::SS_ACKA: begin
					if (sclFall) begin
						bitCnt <= 4'h0;
						if (isRead) begin
							// The alert reply identifies this slave.
							shiftReg <= isAra ? ogac_pkg::ARA_REPLY : ogac_pkg::IDLE_BYTE;
							state <= ogac_pkg::SS_TX;
							sdaOe <= isAra ? ~ogac_pkg::ARA_REPLY[7] : ~ogac_pkg::IDLE_BYTE[7];
							bitCnt <= 4'h1;
						end else begin
							state <= ogac_pkg::SS_RX;
							sdaOe <= 1'b0;
						end
					end
				end
				ogac_pkg::SS_ACKRX: begin
					if (sclFall) begin
						state <= ogac_pkg::SS_RX;
						bitCnt <= 4'h0;
						sdaOe <= 1'b0;
					end
				end
				ogac_pkg::SS_TX: begin
					if (sclFall) begin
						if (bitCnt == ogac_pkg::BYTE_BITS) begin
							state <= ogac_pkg::SS_ACKTX;
							sdaOe <= 1'b0;
							// Alert byte fully sent: tell the logic clock side.
							if (isAra) begin
								araToggle <= ~araToggle;
							end
						end else begin
							shiftReg <= {shiftReg[6:0], 1'b1};
							sdaOe <= ~shiftReg[6];
							bitCnt <= bitCnt + 4'h1;
						end
					end
				end
				ogac_pkg::SS_ACKTX: begin
					// A host nack ends the read; an ack asks for one more idle byte.
					if (sclRise) begin
						if (sdaS) begin
							state <= ogac_pkg::SS_IDLE;
						end else begin
							isAra <= 1'b0;
							shiftReg <= ogac_pkg::IDLE_BYTE;
							bitCnt <= 4'h0;
							state <= ogac_pkg::SS_ACKA;
						end
					end
				end
				default: begin
					state <= ogac_pkg::SS_IDLE;
					sdaOe <= 1'b0;
				end
			endcase
		end
	end
endmodule

// file: design/ogac_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/100ps
module ogac_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] meta;

	// Both stages clear under reset and then shift on every edge.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// file: design/ogac_top.sv
// Gate drivers, alert line, reset sequencing and shutdown control.
//
// Notes on behaviour
// - Charge gate follows force bits, flag, comparator.
// - Discharge gate follows force bits, flag, comparator.
// - Both gates released during reset timeout.
// - Overcurrent, optionally compare or direction, raises alert.
// - Alert holds until clear bit, reply, reset.
// - Alert address read returns 0x8F while pending.
// - Reset low at power-up, hard off, low rail.
// - Reset releases 25 ms after rail is high.
// - No reset for brownout between thresholds.
// - Shutdown pin low forces full reset state.
// - Soft off entry clears alerts and flags.
// - Bus stays working during soft off.
// - Leaving soft off keeps state, no reset.
// - Device is a bus slave only.
// - Start condition detected and tracked.
// - Fixed address 1000111 answered, plus alert address reads while alert pending.
// - Overcurrent flags set, clear on clear events.
// - Free-running gate still latches alert once.
`timescale 1ns/100ps
module ogac_top #(
	// Reset timeout in logic clock cycles; shorten for simulation.
	parameter longint unsigned POR_CYCLES = ogac_pkg::POR_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic linkClk,
	input wire logic hard_off_n,
	input wire logic rail_above_low,
	input wire logic rail_above_release,
	input wire logic charge_comparator_out,
	input wire logic discharge_comparator_out,
	input wire logic charge_gate_force_high,
	input wire logic charge_gate_force_low,
	input wire logic discharge_gate_force_high,
	input wire logic discharge_gate_force_low,
	input wire logic clear_alerts_bit,
	input wire logic soft_off_bit,
	input wire logic compareMatch,
	input wire logic compareAlertEn,
	input wire logic dirChange,
	input wire logic dirAlertEn,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOe,
	output logic charge_gate_drive_oe,
	output logic discharge_gate_drive_oe,
	output logic alertOe,
	output logic resetOutOe,
	output logic charge_overcurrent_flag,
	output logic discharge_overcurrent_flag,
	output logic softOffState,
	output logic porActive
);
	// =====================================================
	// Input synchronisation
	// =====================================================
	// Pins and analog comparator levels come from outside the logic clock.
	logic [4:0] pinSync;
	// Synchronised shutdown pin, rail comparators and overcurrent comparators.
	logic hardOffS;
	logic railLowOkS;
	logic railRelOkS;
	logic chgCmpS;
	logic dchCmpS;

	// Two flip-flops ahead of every comparator and pin reader.
	ogac_sync #(.WIDTH(5)) uPinSync (
		.clk(mclk),
		.rst_b(rst_b),
		.d({discharge_comparator_out, charge_comparator_out, rail_above_release, rail_above_low, hard_off_n}),
		.q(pinSync)
	);

	assign hardOffS = pinSync[0];
	assign railLowOkS = pinSync[1];
	assign railRelOkS = pinSync[2];
	assign chgCmpS = pinSync[3];
	assign dchCmpS = pinSync[4];

	// =====================================================
	// Power-on reset sequencer
	// =====================================================
	// Sequencer state and timeout counter.
	ogac_pkg::ogac_rst_e rstState;
	logic [ogac_pkg::POR_CNT_W-1:0] porCnt;
	// Last count of the timeout, sized to the counter.
	localparam logic [ogac_pkg::POR_CNT_W-1:0] POR_LAST = ogac_pkg::POR_CNT_W'(POR_CYCLES - 64'd1);
	// Conditions that force the reset state at any time.
	logic forceReset;
	// Hard shutdown or a rail below the low threshold.
	assign forceReset = ~hardOffS | ~railLowOkS;

	// Hold in reset, count the timeout once the rail passes the release level,
	// then run. In run only the forcing conditions return to hold, so a rail
	// sagging between the two thresholds is ignored.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstState <= ogac_pkg::RS_HOLD;
			porCnt <= '0;
		end else if (forceReset) begin
			rstState <= ogac_pkg::RS_HOLD;
			porCnt <= '0;
		end else begin
			case (rstState)
				ogac_pkg::RS_HOLD: begin
					porCnt <= '0;
					if (railRelOkS) begin
						rstState <= ogac_pkg::RS_WAIT;
					end
				end
				ogac_pkg::RS_WAIT: begin
					// A rail falling back below release restarts the timeout.
					if (!railRelOkS) begin
						rstState <= ogac_pkg::RS_HOLD;
					end else if (porCnt == POR_LAST) begin
						rstState <= ogac_pkg::RS_RUN;
					end else begin
						porCnt <= porCnt + 1'b1;
					end
				end
				ogac_pkg::RS_RUN: begin
					rstState <= ogac_pkg::RS_RUN;
				end
				default: begin
					rstState <= ogac_pkg::RS_HOLD;
				end
			endcase
		end
	end

	// Reset is active in every state but run.
	logic next_porActive;
	assign next_porActive = forceReset || (rstState != ogac_pkg::RS_RUN);

	// Registered reset flag and open-drain reset pin drive.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			porActive <= 1'b1;
			resetOutOe <= 1'b1;
		end else begin
			porActive <= next_porActive;
			resetOutOe <= next_porActive;
		end
	end

	// =====================================================
	// Soft shutdown
	// =====================================================
	// Entering soft shutdown is the rising edge of the configuration bit.
	logic softEntry;
	assign softEntry = soft_off_bit & ~softOffState & ~porActive;

	// Soft shutdown never touches the reset sequencer, so leaving it keeps
	// every stored setting.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			softOffState <= 1'b0;
		end else begin
			softOffState <= soft_off_bit & ~porActive;
		end
	end

	// =====================================================
	// Overcurrent flags
	// =====================================================
	// Overcurrent is sensed only while the analog side is powered.
	logic sensing;
	logic chgSet;
	logic dchSet;
	assign sensing = ~porActive & ~softOffState & ~soft_off_bit;
	assign chgSet = sensing & chgCmpS;
	assign dchSet = sensing & dchCmpS;

	// Common clear for the status and alert latches, apart from the reply.
	logic flagClear;
	assign flagClear = clear_alerts_bit | softEntry;

	// Flags set on overcurrent; a set in the clear cycle wins. Reset clears
	// unconditionally since the whole device is being reinitialised.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			charge_overcurrent_flag <= 1'b0;
			discharge_overcurrent_flag <= 1'b0;
		end else if (porActive) begin
			charge_overcurrent_flag <= 1'b0;
			discharge_overcurrent_flag <= 1'b0;
		end else begin
			charge_overcurrent_flag <= chgSet | (charge_overcurrent_flag & ~flagClear);
			discharge_overcurrent_flag <= dchSet | (discharge_overcurrent_flag & ~flagClear);
		end
	end

	// =====================================================
	// Gate drivers
	// =====================================================
	// Open-drain decode: one means the gate is pulled low.
	function automatic logic gateSink(input logic forceHi, input logic forceLo, input logic flag,
		input logic cmp);
		case ({forceHi, forceLo})
			2'b00: gateSink = ~flag;
			2'b01: gateSink = 1'b1;
			2'b10: gateSink = 1'b0;
			2'b11: gateSink = ~cmp;
			default: gateSink = 1'b0;
		endcase
	endfunction

	// Free-running mode follows the synchronised comparator; the two-cycle
	// lag is tiny next to the slow open-drain turn-off. Both gates are high
	// impedance for the whole reset timeout.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			charge_gate_drive_oe <= 1'b0;
			discharge_gate_drive_oe <= 1'b0;
		end else if (next_porActive) begin
			charge_gate_drive_oe <= 1'b0;
			discharge_gate_drive_oe <= 1'b0;
		end else begin
			charge_gate_drive_oe <= gateSink(charge_gate_force_high, charge_gate_force_low,
				charge_overcurrent_flag, chgCmpS);
			discharge_gate_drive_oe <= gateSink(discharge_gate_force_high, discharge_gate_force_low,
				discharge_overcurrent_flag, dchCmpS);
		end
	end

	// =====================================================
	// Alert line
	// =====================================================
	// Reply toggle from the link clock and its edge detector.
	logic araToggle;
	logic araSync;
	logic araPrev;
	logic araDone;

	ogac_sync #(.WIDTH(1)) uAraSync (
		.clk(mclk),
		.rst_b(rst_b),
		.d(araToggle),
		.q(araSync)
	);

	// Remember the synchronised toggle to turn a change into one pulse.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			araPrev <= 1'b0;
		end else begin
			araPrev <= araSync;
		end
	end
	assign araDone = araSync ^ araPrev;

	// Alert causes: overcurrent always, compare and direction when enabled.
	logic alertSet;
	assign alertSet = chgSet | dchSet | (sensing & ((compareMatch & compareAlertEn) |
		(dirChange & dirAlertEn)));

	// Alert latch: held low until cleared; a cause in the clearing cycle
	// wins. The comparator level keeps setting it in free-running mode, so
	// the line stays low while the gate pulses.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			alertOe <= 1'b0;
		end else if (porActive) begin
			alertOe <= 1'b0;
		end else begin
			alertOe <= alertSet | (alertOe & ~(flagClear | araDone));
		end
	end

	// =====================================================
	// Bus interface
	// =====================================================
	// The bus front end has its own clock and ignores soft shutdown, so
	// the host can still reach the device.
	ogac_smbus_slave uSlave (
		.linkClk(linkClk),
		.rst_b(rst_b),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.alertPending(alertOe),
		.sdaOe(sdaOe),
		.araToggle(araToggle)
	);
endmodule

// file: tb/ogac_host.sv
// Bus host model: it alone starts transfers, and reads data through the pull-up.
`timescale 1ns/100ps
module ogac_host #(
	parameter int QTR = 320
) (
	output logic scl,
	output logic sdaDrv,
	input wire logic sdaLine
);
	// Both lines idle released.
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	// Start or repeated start: data falls while the clock is high.
	task automatic startCond();
		sdaDrv = 1'b1;
		#QTR scl = 1'b1;
		#QTR sdaDrv = 1'b0;
		#QTR scl = 1'b0;
	endtask
	// Stop: data rises while the clock is high, then the clock stands still.
	task automatic stopCond();
		sdaDrv = 1'b0;
		#QTR scl = 1'b1;
		#QTR sdaDrv = 1'b1;
		#QTR;
	endtask
	// One bit: data changes only with the clock low, sampled mid high phase.
	task automatic bitCycle(input logic tx, output logic rx);
		#QTR sdaDrv = tx;
		#QTR scl = 1'b1;
		#QTR rx = sdaLine;
		#QTR scl = 1'b0;
	endtask
	// Eight bits MSB first, then the acknowledge slot; sending ones lets the slave drive.
	task automatic xferByte(input logic [7:0] tx, input logic hostAck, output logic [7:0] rx, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(tx[i], b);
			rx[i] = b;
		end
		bitCycle(hostAck, b);
		ack = !b;
	endtask
endmodule

// file: tb/ogac_top_properties.sv
// Timing checker for the gate, alert and reset outputs of ogac_top.
`timescale 1ns/100ps
module ogac_top_properties #(
	parameter longint unsigned POR_CYCLES = 200
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic hard_off_n,
	input wire logic rail_above_low,
	input wire logic rail_above_release,
	input wire logic charge_comparator_out,
	input wire logic discharge_comparator_out,
	input wire logic charge_gate_force_high,
	input wire logic charge_gate_force_low,
	input wire logic discharge_gate_force_high,
	input wire logic discharge_gate_force_low,
	input wire logic clear_alerts_bit,
	input wire logic soft_off_bit,
	input wire logic compareMatch,
	input wire logic dirChange,
	input wire logic charge_gate_drive_oe,
	input wire logic discharge_gate_drive_oe,
	input wire logic alertOe,
	input wire logic resetOutOe,
	input wire logic charge_overcurrent_flag,
	input wire logic discharge_overcurrent_flag,
	input wire logic softOffState,
	input wire logic porActive
);
	// ==================================================
	// Helper logic
	// ==================================================
	// Cycles with all supply conditions good; a restart of the timeout must show here too.
	logic [31:0] railCnt;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Counts good-supply cycles, saturating so a long run never wraps.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			railCnt <= 32'h0;
		end else if (!(hard_off_n && rail_above_low && rail_above_release)) begin
			railCnt <= 32'h0;
		end else if (railCnt != 32'hFFFFFFFF) begin
			railCnt <= railCnt + 32'h1;
		end
	end
	// One cycle of clear with no event source active; the check below repeats it four times.
	sequence quietClear;
		clear_alerts_bit && !charge_comparator_out && !discharge_comparator_out && !compareMatch && !dirChange;
	endsequence
	// ==================================================
	// Assertions
	// ==================================================
	a_force_on_charge: assert property ((!charge_gate_force_high && charge_gate_force_low) |=>
		(charge_gate_drive_oe || porActive)) else $error("charge gate not forced on");
	a_force_off_charge: assert property ((charge_gate_force_high && !charge_gate_force_low) |=>
		!charge_gate_drive_oe) else $error("charge gate not forced off");
	a_auto_discharge: assert property ((!discharge_gate_force_high && !discharge_gate_force_low) |=>
		(porActive || discharge_gate_drive_oe == !$past(discharge_overcurrent_flag)))
		else $error("discharge gate does not follow its flag");
	a_por_gates_off: assert property (porActive |-> !charge_gate_drive_oe && !discharge_gate_drive_oe)
		else $error("gate driven during reset timeout");
	a_flag_holds: assert property ((discharge_overcurrent_flag && !clear_alerts_bit && !soft_off_bit) |=>
		(discharge_overcurrent_flag || porActive)) else $error("discharge flag dropped");
	a_alert_with_flag: assert property ($rose(charge_overcurrent_flag) |-> alertOe)
		else $error("flag set without alert");
	a_clear_alerts: assert property (quietClear [*4] |=>
		!alertOe && !charge_overcurrent_flag && !discharge_overcurrent_flag) else $error("clear ignored");
	a_soft_entry: assert property (($rose(soft_off_bit) && !porActive) |=> softOffState && !alertOe &&
		!charge_overcurrent_flag && !discharge_overcurrent_flag) else $error("soft entry kept alerts");
	a_hard_off_reset: assert property ((!hard_off_n) [*4] |=> resetOutOe && porActive && !alertOe)
		else $error("hard off without reset state");
	a_no_brownout: assert property ((!porActive && rail_above_low && hard_off_n) [*4] |=> !porActive)
		else $error("reset asserted between thresholds");
	a_por_timeout: assert property ($fell(porActive) |-> 64'(railCnt) >= POR_CYCLES &&
		64'(railCnt) <= POR_CYCLES + 16) else $error("reset timeout length wrong");
endmodule

bind ogac_top ogac_top_properties #(.POR_CYCLES(POR_CYCLES)) ogac_top_properties_inst (.*);

// file: tb/tb_ogac_top.sv
// Self-checking bench for gates, alert, reset sequencing and bus replies.
`timescale 1ns/100ps
module tb_ogac_top;
	// ==================================================
	// Signals
	// ==================================================
	logic mclk, rst_b, linkClk, hard_off_n, rail_above_low, rail_above_release;
	logic charge_comparator_out, discharge_comparator_out, clear_alerts_bit, soft_off_bit;
	logic charge_gate_force_high, charge_gate_force_low, discharge_gate_force_high, discharge_gate_force_low;
	logic compareMatch, compareAlertEn, dirChange, dirAlertEn, sclIn, sdaDrv, sdaOe, ack;
	logic charge_gate_drive_oe, discharge_gate_drive_oe, alertOe, resetOutOe;
	logic charge_overcurrent_flag, discharge_overcurrent_flag, softOffState, porActive;
	// Data line has a pull-up: it is low when either party pulls it.
	wire logic sdaIn = sdaDrv & ~sdaOe;
	// Gate enables per force setting, flag clear (bits 3..0) then flag set (bits 7..4).
	localparam logic [7:0] GATE_EXP = 8'hAB;
	int failCount, checksDone;
	logic [7:0] rx;
	ogac_top #(.POR_CYCLES(200)) ogac_top_inst (.*);
	ogac_host ogac_host_inst (.scl(sclIn), .sdaDrv(sdaDrv), .sdaLine(sdaIn));
	// Logic clock 20 ns; link clock 64 ns with an unrelated phase.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		linkClk = 1'b0;
		#7;
		forever #32 linkClk = ~linkClk;
	end
	// ==================================================
	// Tasks
	// ==================================================
	task completeRun;
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task setForce(input logic [1:0] m);
		{charge_gate_force_high, charge_gate_force_low} = m;
		{discharge_gate_force_high, discharge_gate_force_low} = m;
	endtask
	task cmpLevel(input logic v, input int n);
		charge_comparator_out = v;
		discharge_comparator_out = v;
		tick(n);
	endtask
	// Clear bit held for four cycles.
	task clearAll;
		clear_alerts_bit = 1'b1;
		tick(4);
		clear_alerts_bit = 1'b0;
		tick(2);
	endtask
	// Bounded wait for the reset timeout to end; running out ends the run.
	task waitPor;
		for (int k = 0; k < 600 && porActive !== 1'b0; k++)
			tick(1);
		if (porActive !== 1'b0) begin
			failCount++;
			completeRun();
		end
	endtask
	// Address byte, one data byte (reads end on host NACK), then stop.
	task busXfer(input logic [7:0] addr);
		logic [7:0] junk;
		logic n;
		rx = 8'h00;
		ogac_host_inst.startCond();
		ogac_host_inst.xferByte(addr, 1'b1, junk, ack);
		if (ack)
			ogac_host_inst.xferByte(addr[0] ? 8'hFF : 8'h0A, 1'b1, rx, n);
		ack = ack & (addr[0] | n);
		ogac_host_inst.stopCond();
		tick(4);
	endtask
	// ==================================================
	// Scenarios
	// ==================================================
	initial begin
		{charge_comparator_out, discharge_comparator_out, clear_alerts_bit, soft_off_bit} = 4'h0;
		{compareMatch, compareAlertEn, dirChange, dirAlertEn} = 4'h0;
		setForce(2'h0);
		{hard_off_n, rail_above_low, rail_above_release} = 3'h7;
		rst_b = 1'b0;
		tick(5);
		rst_b = 1'b1;
		tick(3);
		check("por gates", {charge_gate_drive_oe, discharge_gate_drive_oe, resetOutOe}, 8'h01);
		waitPor();
		// Every force setting, first with flags clear, then latched by a free-running overcurrent.
		for (int i = 0; i < 8; i++) begin
			setForce(i[1:0]);
			tick(3);
			check("gate mode", {charge_gate_drive_oe, discharge_gate_drive_oe}, {2{GATE_EXP[i]}});
			if (i == 3) begin
				cmpLevel(1'b1, 5);
				check("free gate", {charge_gate_drive_oe, discharge_gate_drive_oe}, 8'h00);
				cmpLevel(1'b0, 5);
				check("free alert", {alertOe, charge_overcurrent_flag, discharge_overcurrent_flag,
					charge_gate_drive_oe, discharge_gate_drive_oe}, 8'h1F);
			end
		end
		clearAll();
		check("clear", {alertOe, charge_overcurrent_flag, discharge_overcurrent_flag}, 8'h00);
		setForce(2'h0);
		compareMatch = 1'b1;
		tick(3);
		check("compare masked", alertOe, 8'h00);
		compareAlertEn = 1'b1;
		tick(3);
		check("compare alert", alertOe, 8'h01);
		{compareMatch, compareAlertEn, dirChange, dirAlertEn} = 4'h3;
		tick(3);
		clearAll();
		check("direction alert held", alertOe, 8'h01);
		{dirChange, dirAlertEn} = 2'h0;
		clearAll();
		// Own address in both directions, a foreign address, then alert replies.
		busXfer({ogac_pkg::OWN_ADDR, 1'b0});
		check("own write ack", ack, 8'h01);
		busXfer({ogac_pkg::OWN_ADDR, 1'b1});
		check("own read", {ack, rx[6:0]}, 8'hFF);
		busXfer(8'h90);
		check("foreign nack", ack, 8'h00);
		busXfer({ogac_pkg::ARA_ADDR, 1'b1});
		check("ara idle nack", ack, 8'h00);
		cmpLevel(1'b1, 4);
		cmpLevel(1'b0, 4);
		busXfer({ogac_pkg::ARA_ADDR, 1'b1});
		check("ara reply", rx, ogac_pkg::ARA_REPLY);
		tick(10);
		check("ara clears", {ack, alertOe, charge_overcurrent_flag, discharge_overcurrent_flag}, 8'h0B);
		// Soft off entered with both gates forced off; the bus stays alive.
		setForce(2'h2);
		soft_off_bit = 1'b1;
		tick(3);
		check("soft entry", {softOffState, alertOe, charge_overcurrent_flag, discharge_overcurrent_flag}, 8'h08);
		cmpLevel(1'b1, 4);
		cmpLevel(1'b0, 4);
		busXfer({ogac_pkg::OWN_ADDR, 1'b0});
		check("soft bus", {ack, charge_overcurrent_flag, discharge_overcurrent_flag}, 8'h04);
		soft_off_bit = 1'b0;
		tick(3);
		check("soft exit", {softOffState, porActive, resetOutOe, charge_gate_drive_oe}, 8'h00);
		// Brownout is ignored; a low rail restarts the whole timeout.
		setForce(2'h0);
		rail_above_release = 1'b0;
		tick(20);
		check("brownout", {porActive, resetOutOe}, 8'h00);
		rail_above_low = 1'b0;
		tick(5);
		check("low rail", {resetOutOe, charge_gate_drive_oe, discharge_gate_drive_oe}, 8'h04);
		rail_above_low = 1'b1;
		tick(50);
		check("below release", resetOutOe, 8'h01);
		rail_above_release = 1'b1;
		waitPor();
		// Hard off with a latched flag forces the full reset state.
		cmpLevel(1'b1, 4);
		cmpLevel(1'b0, 4);
		hard_off_n = 1'b0;
		tick(5);
		check("hard off", {resetOutOe, alertOe, charge_overcurrent_flag, discharge_overcurrent_flag}, 8'h08);
		hard_off_n = 1'b1;
		tick(100);
		check("hard exit gates", {charge_gate_drive_oe, discharge_gate_drive_oe}, 8'h00);
		waitPor();
		tick(3);
		check("gates back", {charge_gate_drive_oe, discharge_gate_drive_oe}, 8'h03);
		completeRun();
	end
endmodule
